//--- design/adc_rate_accum_compare.sv
// primary-channel result pacing, accumulator, threshold comparator and ground switch
//
// How it works
// - normal rate 512000/((sf+1)*64), further divided by averaging or chop terms
// - low power uses 131072 Hz in place of 512000 Hz everywhere
// - settling periods: 3 plain, 4 running avg, 1 avg, 2 avg+ravg, 2 chop
// - about 60 us per enabled converter precedes the first result
// - extended configuration is eight bits, read/write, reset to zero
// - bit 7 set connects ground switch pin; clear disconnects it
// - ground switch together with bit 1 selects series resistor
// - accumulator mode 00 disables and clears the accumulator
// - mode 01 adds signed results and clamps total at zero
// - mode 10 adds signed results with no clamp below zero
// - accumulator is 32 bits and wraps with no top saturation
// - mode 11 clamps at zero like mode 01; compare runs per compare mode in any mode; its interrupt only with mask bit 6
// - compare mode 00 off; 01 flags every result with magnitude at threshold
// - compare mode 10 counts hits, flags at count, a miss clears counter
// - compare mode 11 like 10 but a miss decrements toward zero
// - filter register: chop 15, running avg 14, averaging 13:8, decimation 6:0
// - decimation 126 forces 60 Hz, 127 forces 50 Hz
// - any filter register write resets both converters
`include "adc_rate_params.svh"
module adc_rate_accum_compare
   import adc_rate_pkg::*;
#(
   parameter int STARTUP_CYCLES = `STARTUP_CYCLES,
   parameter int COUNT_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [23:0] sample_data,
   output logic ground_switch_pin,
   output logic ground_series_res,
   output logic converter_reset,
   output logic primary_ready,
   output logic primary_irq
);

   // -------------------------------------------------------------
   // address decode
   // -------------------------------------------------------------
   function automatic reg_sel_t decode(input logic [31:0] addr);
      reg_sel_t sel;
      sel = SEL_NONE;
      if (addr == `ADDR_FILTER_CONFIG) sel = SEL_FILTER;
      else if (addr == `ADDR_EXT_CONFIG) sel = SEL_EXT;
      else if (addr == `ADDR_MODE_CONTROL) sel = SEL_MODE;
      else if (addr == `ADDR_THRESHOLD) sel = SEL_THRESH;
      else if (addr == `ADDR_THRESHOLD_COUNT) sel = SEL_TCOUNT;
      else if (addr == `ADDR_THRESHOLD_COUNTER) sel = SEL_TCOUNTER;
      else if (addr == `ADDR_ACCUMULATOR) sel = SEL_ACCUM;
      else if (addr == `ADDR_INTERRUPT_MASK) sel = SEL_MASK;
      else if (addr == `ADDR_STATUS_FLAGS) sel = SEL_STATUS;
      else if (addr == `ADDR_RESULT) sel = SEL_RESULT;
      return sel;
   endfunction

   wire reg_sel_t sel = decode(paddr);
   wire setup_phase = psel && !penable;
   // no wait state: pready rises in the first access cycle
   wire access_done = psel && penable && pready;
   wire wr_done = access_done && pwrite;
   wire rd_done = access_done && !pwrite;

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   filter_cfg_t adc_filter_config;
   ext_cfg_t adc_extended_config;
   mode_ctl_t mode_control;
   logic [23:0] primary_threshold;
   logic [COUNT_W-1:0] primary_threshold_count;
   logic [COUNT_W-1:0] primary_threshold_counter;
   logic [31:0] accumulator;
   logic [7:0] adc_interrupt_mask;
   logic ready_flag;
   logic compare_flag;
   logic [23:0] result;

   wire filter_write = wr_done && sel == SEL_FILTER;
   wire status_read = rd_done && sel == SEL_STATUS;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_filter_config <= filter_cfg_t'(`RESET_FILTER_CONFIG);
         adc_extended_config <= ext_cfg_t'(`RESET_EXT_CONFIG);
         mode_control <= mode_ctl_t'(`RESET_MODE_CONTROL);
         primary_threshold <= 24'h0;
         primary_threshold_count <= '0;
         adc_interrupt_mask <= 8'h0;
      end else if (ce && wr_done) begin
         if (sel == SEL_FILTER) adc_filter_config <= filter_cfg_t'(pwdata[15:0]);
         if (sel == SEL_EXT) adc_extended_config <= ext_cfg_t'(pwdata[7:0]);
         if (sel == SEL_MODE) mode_control <= mode_ctl_t'(pwdata[2:0]);
         if (sel == SEL_THRESH) primary_threshold <= pwdata[23:0];
         if (sel == SEL_TCOUNT) primary_threshold_count <= pwdata[COUNT_W-1:0];
         if (sel == SEL_MASK) adc_interrupt_mask <= pwdata[7:0];
      end
   end

   // -------------------------------------------------------------
   // result pacing
   // -------------------------------------------------------------
   logic result_strobe;
   logic restart_timer;

   adc_rate_timer #(
      .STARTUP_CYCLES(STARTUP_CYCLES)
   ) timer (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .restart(restart_timer),
      .mode(mode_control),
      .flt(adc_filter_config),
      .result_strobe(result_strobe)
   );

   // -------------------------------------------------------------
   // accumulator
   // -------------------------------------------------------------
   wire signed [31:0] sample_ext = 32'(signed'(sample_data));
   wire sample_neg = sample_data[23];
   wire [31:0] acc_sum = accumulator + sample_ext;   // wraps at the top
   wire accum_mode_t amode = adc_extended_config.primary_accum_mode;
   wire clamp_mode = amode == ACC_CLAMP || amode == ACC_WITH_COMPARE;
   // clamp only when a subtraction crosses zero, so an upward wrap is left alone
   wire below_zero = sample_neg && (accumulator < 32'(-sample_ext));
   wire [31:0] next_accumulator =
      (amode == ACC_OFF) ? 32'h0 :
      (clamp_mode && below_zero) ? 32'h0 :
      acc_sum;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         accumulator <= 32'h0;
      else if (ce && (amode == ACC_OFF || result_strobe))
         accumulator <= next_accumulator;
   end

   // -------------------------------------------------------------
   // threshold comparator
   // -------------------------------------------------------------
   wire [23:0] magnitude = sample_neg ? 24'(-sample_data) : sample_data;
   wire at_threshold = magnitude >= primary_threshold;
   wire cmp_mode_t cmode = adc_extended_config.primary_compare_mode;
   wire [COUNT_W-1:0] counter_up = primary_threshold_counter + COUNT_W'(1);
   logic [COUNT_W-1:0] next_counter;
   logic compare_hit;

   always_comb begin
      next_counter = primary_threshold_counter;
      compare_hit = 1'b0;
      case (cmode)
         CMP_OFF: next_counter = '0;
         CMP_EACH: compare_hit = at_threshold;
         CMP_COUNT_RESET: begin
            if (!at_threshold) next_counter = '0;
            else if (counter_up >= primary_threshold_count) begin
               next_counter = '0;
               compare_hit = 1'b1;
            end else next_counter = counter_up;
         end
         CMP_COUNT_DECR: begin
            if (!at_threshold) begin
               if (primary_threshold_counter != '0)
                  next_counter = primary_threshold_counter - COUNT_W'(1);
            end else if (counter_up >= primary_threshold_count) begin
               next_counter = '0;
               compare_hit = 1'b1;
            end else next_counter = counter_up;
         end
         default: next_counter = '0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         primary_threshold_counter <= '0;
      else if (ce && result_strobe)
         primary_threshold_counter <= next_counter;
   end

   // -------------------------------------------------------------
   // result, flags, outputs
   // -------------------------------------------------------------
   // a new event in the clearing cycle survives the clear
   wire next_ready = result_strobe || (ready_flag && !status_read);
   wire next_compare = (result_strobe && compare_hit) || (compare_flag && !status_read);
   wire next_irq = (next_ready && adc_interrupt_mask[`MASK_READY_BIT])
                   || (next_compare && adc_interrupt_mask[`MASK_COMPARE_BIT]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result <= 24'h0;
         ready_flag <= 1'b0;
         compare_flag <= 1'b0;
         primary_ready <= 1'b0;
         primary_irq <= 1'b0;
         ground_switch_pin <= 1'b0;
         ground_series_res <= 1'b0;
         converter_reset <= 1'b0;
         restart_timer <= 1'b0;
      end else if (ce) begin
         if (result_strobe) result <= sample_data;
         ready_flag <= next_ready;
         compare_flag <= next_compare;
         primary_ready <= next_ready;
         primary_irq <= next_irq;
         ground_switch_pin <= adc_extended_config.ground_switch_enable;
         ground_series_res <= adc_extended_config.ground_switch_enable
                              && adc_extended_config.series_res_enable;
         converter_reset <= filter_write;
         restart_timer <= filter_write;
      end
   end

   // -------------------------------------------------------------
   // bus answer
   // -------------------------------------------------------------
   logic [31:0] read_value;

   always_comb begin
      case (sel)
         SEL_FILTER: read_value = {16'h0, adc_filter_config};
         SEL_EXT: read_value = {24'h0, adc_extended_config};
         SEL_MODE: read_value = {29'h0, mode_control};
         SEL_THRESH: read_value = {8'h0, primary_threshold};
         SEL_TCOUNT: read_value = 32'(primary_threshold_count);
         SEL_TCOUNTER: read_value = 32'(primary_threshold_counter);
         SEL_ACCUM: read_value = accumulator;
         SEL_MASK: read_value = {24'h0, adc_interrupt_mask};
         SEL_STATUS: read_value = 32'(ready_flag) | (32'(compare_flag) << `STATUS_COMPARE_BIT);
         SEL_RESULT: read_value = {8'h0, result};
         default: read_value = 32'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else if (ce) begin
         pready <= setup_phase;
         pslverr <= setup_phase && sel == SEL_NONE;
         if (setup_phase) prdata <= read_value;
      end
   end

endmodule

//--- design/adc_rate_params.svh
// offsets, field positions, reset values and timing counts of the rate/accumulate block
`ifndef ADC_RATE_PARAMS_SVH
`define ADC_RATE_PARAMS_SVH

// -------------------------------------------------------------
// register byte addresses
// -------------------------------------------------------------
`define ADDR_FILTER_CONFIG 32'hffff0514
`define ADDR_EXT_CONFIG 32'hffff0518
`define ADDR_MODE_CONTROL 32'hffff0540
`define ADDR_THRESHOLD 32'hffff0544
`define ADDR_THRESHOLD_COUNT 32'hffff0548
`define ADDR_THRESHOLD_COUNTER 32'hffff054c
`define ADDR_ACCUMULATOR 32'hffff0550
`define ADDR_INTERRUPT_MASK 32'hffff0554
`define ADDR_STATUS_FLAGS 32'hffff0558
`define ADDR_RESULT 32'hffff055c

// -------------------------------------------------------------
// reset values
// -------------------------------------------------------------
`define RESET_FILTER_CONFIG 16'h0007
`define RESET_EXT_CONFIG 8'h00
`define RESET_MODE_CONTROL 3'h3

// -------------------------------------------------------------
// field positions
// -------------------------------------------------------------
`define EXT_GROUND_SWITCH 7
`define EXT_SERIES_RES 1
`define MASK_READY_BIT 0
`define MASK_COMPARE_BIT 6
`define STATUS_READY_BIT 0
`define STATUS_COMPARE_BIT 6

// -------------------------------------------------------------
// timing
// -------------------------------------------------------------
`define PCLK_HZ 20000000
`define MOD_HZ_NORMAL 512000
`define MOD_HZ_LOW_POWER 131072
`define DECIM_BLOCK 64
`define CHOP_EXTRA 3
`define AVG_BASE 3
`define FORCED_60_SF 7'd126
`define FORCED_50_SF 7'd127
`define FORCED_60_HZ 60
`define FORCED_50_HZ 50
`define STARTUP_NS 60000
`define STARTUP_CYCLES ((`STARTUP_NS * (`PCLK_HZ / 1000000) + 999) / 1000)

`endif

//--- design/adc_rate_pkg.sv
// types shared by the rate timer and the accumulate/compare block
package adc_rate_pkg;

   typedef struct packed {
      logic chop_enable;
      logic running_average_enable;
      logic [5:0] averaging_factor;
      logic notch_modify;
      logic [6:0] decimation_factor;
   } filter_cfg_t;

   typedef enum logic [1:0] {
      ACC_OFF = 2'b00,
      ACC_CLAMP = 2'b01,
      ACC_FREE = 2'b10,
      ACC_WITH_COMPARE = 2'b11
   } accum_mode_t;

   typedef enum logic [1:0] {
      CMP_OFF = 2'b00,
      CMP_EACH = 2'b01,
      CMP_COUNT_RESET = 2'b10,
      CMP_COUNT_DECR = 2'b11
   } cmp_mode_t;

   typedef struct packed {
      logic ground_switch_enable;
      accum_mode_t primary_accum_mode;
      cmp_mode_t primary_compare_mode;
      logic overrange_enable;
      logic series_res_enable;
      logic result_count_enable;
   } ext_cfg_t;

   typedef struct packed {
      logic low_power;
      logic aux_enable;
      logic primary_enable;
   } mode_ctl_t;

   typedef enum logic [1:0] {
      TMR_IDLE = 2'b00,
      TMR_STARTUP = 2'b01,
      TMR_SETTLE = 2'b10,
      TMR_RUN = 2'b11
   } timer_state_t;

   typedef enum logic [3:0] {
      SEL_NONE = 4'h0,
      SEL_FILTER = 4'h1,
      SEL_EXT = 4'h2,
      SEL_MODE = 4'h3,
      SEL_THRESH = 4'h4,
      SEL_TCOUNT = 4'h5,
      SEL_TCOUNTER = 4'h6,
      SEL_ACCUM = 4'h7,
      SEL_MASK = 4'h8,
      SEL_STATUS = 4'h9,
      SEL_RESULT = 4'ha
   } reg_sel_t;

endpackage

//--- design/adc_rate_timer.sv
// output-rate, settling and start-up timer that paces primary results
`include "adc_rate_params.svh"
module adc_rate_timer
   import adc_rate_pkg::*;
#(
   parameter int STARTUP_CYCLES = `STARTUP_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic restart,
   input wire mode_ctl_t mode,
   input wire filter_cfg_t flt,
   output logic result_strobe
);

   // -------------------------------------------------------------
   // modulator tick from pclk by fractional phase accumulation
   // -------------------------------------------------------------
   localparam logic [24:0] PHASE_MOD = 25'(`PCLK_HZ);
   logic [24:0] phase;
   wire [24:0] phase_inc = mode.low_power ? 25'(`MOD_HZ_LOW_POWER) : 25'(`MOD_HZ_NORMAL);
   wire [24:0] phase_sum = phase + phase_inc;
   wire mod_tick = phase_sum >= PHASE_MOD;

   // -------------------------------------------------------------
   // period in modulator ticks
   // -------------------------------------------------------------
   wire [7:0] sf_plus = {1'b0, flt.decimation_factor} + 8'd1;
   wire [6:0] avg_mult = 7'(`AVG_BASE) + {1'b0, flt.averaging_factor};
   wire avg_on = flt.averaging_factor != 6'd0;
   wire [13:0] base_ticks = 14'({sf_plus, 6'd0});
   wire [20:0] chop_ticks = 21'(base_ticks * avg_mult) + 21'(`CHOP_EXTRA);
   wire [20:0] avg_ticks = 21'(base_ticks * avg_mult);
   wire [20:0] forced_60 = mode.low_power ? 21'(`MOD_HZ_LOW_POWER / `FORCED_60_HZ)
                                          : 21'(`MOD_HZ_NORMAL / `FORCED_60_HZ);
   wire [20:0] forced_50 = mode.low_power ? 21'(`MOD_HZ_LOW_POWER / `FORCED_50_HZ)
                                          : 21'(`MOD_HZ_NORMAL / `FORCED_50_HZ);
   wire [20:0] period_ticks =
      (flt.decimation_factor == `FORCED_60_SF) ? forced_60 :
      (flt.decimation_factor == `FORCED_50_SF) ? forced_50 :
      flt.chop_enable ? chop_ticks :
      avg_on ? avg_ticks : 21'(base_ticks);

   // settling in output periods
   wire [2:0] settle_periods =
      flt.chop_enable ? 3'd2 :
      avg_on ? (flt.running_average_enable ? 3'd2 : 3'd1) :
      (flt.running_average_enable ? 3'd4 : 3'd3);

   // start-up grows with the number of enabled converters
   wire [1:0] conv_count = 2'(mode.primary_enable) + 2'(mode.aux_enable);
   wire [12:0] startup_total = 13'(STARTUP_CYCLES) * 13'(conv_count);

   // -------------------------------------------------------------
   // sequencing
   // -------------------------------------------------------------
   timer_state_t state;
   timer_state_t next_state;
   logic [12:0] wait_cnt;
   logic [20:0] tick_cnt;
   logic [2:0] period_cnt;
   wire period_end = mod_tick && (tick_cnt + 21'd1 >= period_ticks);

   always_comb begin
      next_state = state;
      case (state)
         TMR_IDLE: if (mode.primary_enable) next_state = TMR_STARTUP;
         TMR_STARTUP: if (wait_cnt + 13'd1 >= startup_total) next_state = TMR_SETTLE;
         TMR_SETTLE: if (period_end && period_cnt + 3'd1 >= settle_periods) next_state = TMR_RUN;
         TMR_RUN: next_state = TMR_RUN;
         default: next_state = TMR_IDLE;
      endcase
      if (restart || !mode.primary_enable) next_state = TMR_IDLE;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= TMR_IDLE;
         phase <= 25'h0;
         wait_cnt <= 13'h0;
         tick_cnt <= 21'h0;
         period_cnt <= 3'h0;
         result_strobe <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         phase <= mod_tick ? phase_sum - PHASE_MOD : phase_sum;
         wait_cnt <= (state == TMR_STARTUP) ? wait_cnt + 13'd1 : 13'h0;
         if (state != next_state || period_end)
            tick_cnt <= 21'h0;
         else if (mod_tick)
            tick_cnt <= tick_cnt + 21'd1;
         period_cnt <= (state == TMR_SETTLE && period_end) ? period_cnt + 3'd1
                       : (state == TMR_SETTLE ? period_cnt : 3'h0);
         // first result is the one that closes the settling window
         result_strobe <= ((state == TMR_SETTLE && next_state == TMR_RUN)
                           || (state == TMR_RUN && period_end)) && next_state == TMR_RUN;
      end
   end

endmodule

//--- dv/adc_rate_accum_compare_chk.sv
// bound checker on the ports of adc_rate_accum_compare
`include "adc_rate_params.svh"
module adc_rate_accum_compare_chk
   import adc_rate_pkg::*;
#(
   parameter int STARTUP_CYCLES = 4,
   parameter int COUNT_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [23:0] sample_data,
   input wire logic ground_switch_pin,
   input wire logic ground_series_res,
   input wire logic converter_reset,
   input wire logic primary_ready,
   input wire logic primary_irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // -------------------------------------------------------------
   // bus events
   // -------------------------------------------------------------
   wire wr_done = psel && penable && pready && pwrite;
   wire st_rd = psel && penable && pready && !pwrite && paddr == `ADDR_STATUS_FLAGS;
   sequence setup_c;
      psel && !penable && ce;
   endsequence
   sequence ext_wr;
      wr_done && paddr == `ADDR_EXT_CONFIG;
   endsequence
   a_answer_next: assert property (setup_c |=> pready) else $error("no answer after setup");
   a_answer_once: assert property (pready |=> !pready) else $error("answer held too long");
   a_unmapped_zero: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
      else $error("error read not zero");
   a_gnd_follow: assert property (ext_wr ##1 ce |=> ground_switch_pin == $past(pwdata[7], 2))
      else $error("ground switch pin wrong");
   a_gnd_frozen: assert property (ext_wr ##1 !ce |=> $stable(ground_switch_pin))
      else $error("ground switch moved while frozen");
   a_series_gate: assert property (ground_series_res |-> ground_switch_pin)
      else $error("series resistor without switch");
   a_series_follow: assert property (ext_wr ##1 ce |=>
      ground_series_res == ($past(pwdata[7], 2) && $past(pwdata[1], 2)))
      else $error("series resistor wrong");
   a_conv_reset: assert property (wr_done && paddr == `ADDR_FILTER_CONFIG |->
      ##[1:2] converter_reset) else $error("no converter reset");
   a_conv_pulse: assert property (converter_reset |=> !converter_reset)
      else $error("converter reset too long");
   a_ready_sticky: assert property (primary_ready && !st_rd |=> primary_ready)
      else $error("ready flag lost");
   a_irq_cause: assert property (primary_irq |-> primary_ready)
      else $error("interrupt without result");
endmodule
bind adc_rate_accum_compare adc_rate_accum_compare_chk #(.STARTUP_CYCLES(STARTUP_CYCLES),
   .COUNT_W(COUNT_W)) u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sample_data(sample_data),
   .ground_switch_pin(ground_switch_pin), .ground_series_res(ground_series_res),
   .converter_reset(converter_reset), .primary_ready(primary_ready), .primary_irq(primary_irq));

//--- dv/adc_rate_accum_compare_test.sv
// self-checking bench for adc_rate_accum_compare
`include "adc_rate_params.svh"
module adc_rate_accum_compare_test
   import adc_rate_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ce = 1, e, f;
   logic [31:0] paddr = 0, pwdata = 0, prdata, q;
   logic [23:0] sample_data = 0;
   logic pready, pslverr, ground_switch_pin, ground_series_res, converter_reset;
   logic primary_ready, primary_irq;
   logic signed [31:0] acc = 0;
   logic [7:0] ext = 0, mask = 0;
   int mismatches = 0, tests_run = 0, cnt = 0, tcount = 3;
   // sf 0, af 0, no chop: one result every 64 modulator ticks
   localparam time PERIOD_NS = `DECIM_BLOCK * 64'd1000000000 / `MOD_HZ_NORMAL;
   time last_t = 0;
   always #25 pclk = ~pclk;
   // clock enable drops once, after a config write, to show that state freezes
   adc_rate_accum_compare #(.STARTUP_CYCLES(4), .COUNT_W(16)) dut (.pclk(pclk),
      .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_data(sample_data), .ground_switch_pin(ground_switch_pin),
      .ground_series_res(ground_series_res), .converter_reset(converter_reset),
      .primary_ready(primary_ready), .primary_irq(primary_irq));
   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   task stop_test();
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait for the answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [31:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 32'h0);
      chk(q, x);
      chk(32'(e), 32'(xe));
   endtask
   function int rnd();
      return int'($urandom_range(2000)) - 1000;
   endfunction
   // one result: model accumulator and comparator, then compare
   task step(input int s);
      int n, m;
      time dt;
      n = 0;
      m = s < 0 ? -s : s;
      sample_data <= s[23:0];
      while (primary_ready !== 1'b1 && n < 9000) begin
         @(posedge pclk);
         n++;
      end
      chk(32'(n < 9000), 32'h1);
      dt = $time - last_t;
      if (last_t != 0) chk(32'(dt >= PERIOD_NS - 50 && dt <= PERIOD_NS + 50), 32'h1);
      last_t = $time;
      case (ext[6:5])
         2'b00: acc = 0;
         2'b10: acc = acc + s;
         default: acc = (s < 0 && -s > acc) ? 0 : acc + s;
      endcase
      f = 1'b0;
      if (ext[4:3] == 2'b01) f = (m >= 500);
      else if (ext[4:3] == 2'b00) cnt = 0;
      else if (m >= 500) begin
         f = (cnt + 1 >= tcount);
         cnt = f ? 0 : cnt + 1;
      end else cnt = (ext[4:3] == 2'b10 || cnt == 0) ? 0 : cnt - 1;
      chk(32'(primary_irq), 32'(f & mask[6]));
      apb(1'b0, `ADDR_STATUS_FLAGS, 32'h0);
      chk(q & 32'h41, {25'h0, f, 5'h0, 1'b1});
      rd(`ADDR_ACCUMULATOR, acc, 1'b0);
      rd(`ADDR_RESULT, {8'h0, s[23:0]}, 1'b0);
      if (ext[4:3] != 2'b01) rd(`ADDR_THRESHOLD_COUNTER, 32'(cnt), 1'b0);
   endtask
   task run(input logic [7:0] x, input logic [7:0] k, input int n, input int s[6]);
      int i;
      ext = x;
      mask = k;
      apb(1'b1, `ADDR_EXT_CONFIG, 32'(x));
      apb(1'b1, `ADDR_INTERRUPT_MASK, 32'(k));
      for (i = 0; i < n; i++) begin
         step(s[i]);
      end
   endtask
   // -------------------------------------------------------------
   // sequence
   // -------------------------------------------------------------
   initial begin
      void'($urandom(45));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(`ADDR_FILTER_CONFIG, 32'h7, 1'b0);
      rd(`ADDR_EXT_CONFIG, 32'h0, 1'b0);
      rd(`ADDR_MODE_CONTROL, 32'h3, 1'b0);
      rd(32'hffff0600, 32'h0, 1'b1);
      apb(1'b1, `ADDR_EXT_CONFIG, 32'hffffff82);
      rd(`ADDR_EXT_CONFIG, 32'h82, 1'b0);
      chk(32'({ground_switch_pin, ground_series_res}), 32'h3);
      apb(1'b1, `ADDR_EXT_CONFIG, 32'h80);
      repeat (2) @(posedge pclk);
      chk(32'({ground_switch_pin, ground_series_res}), 32'h2);
      apb(1'b1, `ADDR_EXT_CONFIG, 32'h02);
      ce <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(32'({ground_switch_pin, ground_series_res}), 32'h2);
      ce <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(32'({ground_switch_pin, ground_series_res}), 32'h0);
      // shortest period keeps the run short; the write also restarts pacing
      apb(1'b1, `ADDR_FILTER_CONFIG, 32'h0);
      rd(`ADDR_FILTER_CONFIG, 32'h0, 1'b0);
      apb(1'b1, `ADDR_THRESHOLD, 32'd500);
      apb(1'b1, `ADDR_THRESHOLD_COUNT, 32'(tcount));
      run(8'h20, 8'h00, 4, '{100, -30, -200, rnd(), 0, 0});
      run(8'h00, 8'h00, 2, '{5, 6, 0, 0, 0, 0});
      run(8'h40, 8'h00, 3, '{-300, rnd(), rnd(), 0, 0, 0});
      run(8'h10, 8'h40, 6, '{600, 600, 100, 600, -600, rnd()});
      run(8'h78, 8'h40, 5, '{600, 600, -100, 600, 700, 0});
      run(8'h78, 8'h00, 3, '{600, -600, 900, 0, 0, 0});
      run(8'h08, 8'h40, 3, '{600, -700, rnd(), 0, 0, 0});
      stop_test();
   end
   initial begin
      repeat (90000) @(posedge pclk);
      mismatches++;
      stop_test();
   end
endmodule
